// ===== pmse_pkg.sv
// Purpose: Shared constants for the status, identity and nonvolatile-page command block
// Assumes: Command codes arrive as received on the management bus
// Notes: Identity values are parameters of the top module, not constants here
`default_nettype none
package pmse_pkg;

    // ***************************************************************
    // Command codes
    // ***************************************************************
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_STATUS_LOW_BYTE = 8'h78;
    localparam logic [7:0] CMD_STATUS_FULL_WORD = 8'h79;
    localparam logic [7:0] CMD_TEMPERATURE_ONE = 8'h8d;
    localparam logic [7:0] CMD_TEMPERATURE_TWO = 8'h8e;
    localparam logic [7:0] CMD_PROTOCOL_REVISION = 8'h98;
    localparam logic [7:0] CMD_MAKER_IDENTITY = 8'h99;
    localparam logic [7:0] CMD_MODEL_IDENTITY = 8'h9a;
    localparam logic [7:0] CMD_SILICON_REVISION = 8'h9b;
    localparam logic [3:0] CMD_PAGE_DATA_HIGH = 4'hb;
    localparam logic [7:0] CMD_DOWNLOAD_CHECKSUM = 8'hd1;
    localparam logic [7:0] CMD_READ_LENGTH = 8'hd2;
    localparam logic [7:0] CMD_PAGE_ADDRESS_OFFSET = 8'hd3;
    localparam logic [7:0] CMD_PAGE_WIPE = 8'hd4;
    localparam logic [7:0] CMD_UNLOCK_KEY = 8'hd5;

    // ***************************************************************
    // Field positions
    // ***************************************************************
    localparam int STATUS_FAULT_BIT = 1;
    localparam int STATUS_WIDTH = 16;
    localparam int TEMP_EXP_LSB = 11;
    localparam int TEMP_EXP_WIDTH = 5;
    localparam int TEMP_MANT_WIDTH = 11;

    // ***************************************************************
    // Pages and reset values
    // ***************************************************************
    localparam logic [3:0] FIRST_WRITABLE_PAGE = 4'h4;
    localparam logic [7:0] UNLOCK_KEY_RESET = 8'hff;
    localparam logic [7:0] READ_LENGTH_RESET = 8'h20;
    localparam logic [15:0] PAGE_OFFSET_RESET = 16'h0000;
    localparam logic [7:0] READ_FILL_BYTE = 8'h00;

    typedef enum logic [1:0] {
        PMSE_IDLE,
        PMSE_NVM_WAIT
    } pmse_state_t;

endpackage

`default_nettype wire

// ===== pmse_cmd_interp.sv
// Purpose: Command interpreter for status, temperature, identity and nonvolatile page commands
// Assumes: A bus front end delivers command, write and read-request strobes synchronous to mclk
// Notes: The page array sits outside; reads answer through nvm_rd_valid
//        Strobes during a pending page read are dropped
//        A lost array answer hangs the command side until reset
//        Block writes need the unlock and a writable page, not a wipe
//        The host's wait after a wipe is not timed here
`timescale 1ns/1ps
`default_nettype none

module pmse_cmd_interp
    import pmse_pkg::*;
#(
    parameter logic [7:0] PROTOCOL_REVISION_VALUE = 8'h22, // Arbitrary value
    parameter logic [7:0] MAKER_IDENTITY_VALUE = 8'h5a,    // Arbitrary value
    parameter logic [7:0] MODEL_IDENTITY_VALUE = 8'h3c,    // Arbitrary value
    parameter logic [7:0] SILICON_REVISION_VALUE = 8'h01   // Arbitrary value
) (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic clk_en,
    // Command front end
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic wr_valid,
    input wire logic [7:0] wr_data,
    input wire logic wr_done,
    input wire logic rd_req,
    output logic rd_valid,
    output logic [7:0] rd_data,
    // Fault sources from bus layer
    input wire logic cml_event,
    // Measurements and download result
    input wire logic [4:0] temp_one_exponent,
    input wire logic [10:0] temp_one_mantissa,
    input wire logic [4:0] temp_two_exponent,
    input wire logic [10:0] temp_two_mantissa,
    input wire logic [7:0] download_checksum,
    // Page array port
    output logic nvm_rd_req,
    output logic nvm_wr_req,
    output logic nvm_erase_req,
    output logic [3:0] nvm_page,
    output logic [15:0] nvm_addr,
    output logic [7:0] nvm_wr_data,
    input wire logic nvm_rd_valid,
    input wire logic [7:0] nvm_rd_data,
    // Status
    output logic nvm_unlocked,
    output logic cml_fault
);

    // ***************************************************************
    // State
    // ***************************************************************
    // Transaction
    pmse_state_t state_q, state_d;
    logic [7:0] code_q;
    logic [7:0] idx_q;

    // Fault, lock and key
    logic cml_q;
    logic unlocked_q;
    logic [7:0] key_q;
    logic [7:0] key_prev_q;
    logic key_prev_vld_q;

    // Host settings
    logic [7:0] read_len_q;
    logic [15:0] page_off_q;

    // Output flops
    logic rd_valid_q;
    logic [7:0] rd_data_q;
    logic nvm_rd_req_q;
    logic nvm_wr_req_q;
    logic nvm_erase_req_q;
    logic [3:0] nvm_page_q;
    logic [15:0] nvm_addr_q;
    logic [7:0] nvm_wr_data_q;

    // ***************************************************************
    // Decoding
    // ***************************************************************
    // Pages 0-3 hold defaults, user and internal data
    function automatic logic page_writable(input logic [3:0] page);
        page_writable = (page >= FIRST_WRITABLE_PAGE);
    endfunction

    // Data byte n of a block sits at offset + n - 1; byte 0 is the count
    function automatic logic [15:0] page_byte_addr(input logic [15:0] offset,
        input logic [7:0] index);
        page_byte_addr = offset + {8'h00, index} - 16'h0001;
    endfunction

    wire is_block = (code_q[7:4] == CMD_PAGE_DATA_HIGH);
    wire [3:0] blk_page = code_q[3:0];

    // One match per writable command, shared by commit and fault logic
    wire is_len_cmd = (code_q == CMD_READ_LENGTH);
    wire is_off_cmd = (code_q == CMD_PAGE_ADDRESS_OFFSET);
    wire is_wipe_cmd = (code_q == CMD_PAGE_WIPE);
    wire is_key_cmd = (code_q == CMD_UNLOCK_KEY);
    wire is_clear_cmd = (code_q == CMD_CLEAR_FAULTS);

    // Only the fault bit has state; all others are tied low
    wire [STATUS_WIDTH-1:0] status_word;
    assign status_word = {{(STATUS_WIDTH-STATUS_FAULT_BIT-1){1'b0}}, cml_q,
        1'b0};

    // Sensor values pass through live, sampled at the read
    wire [15:0] temp_one_word = {temp_one_exponent, temp_one_mantissa};
    wire [15:0] temp_two_word = {temp_two_exponent, temp_two_mantissa};

    // Fixed-register read words; only the low byte matters for byte commands
    logic [15:0] fixed_word;
    logic fixed_known;
    always_comb begin
        fixed_word = 16'h0000;
        fixed_known = 1'b1;
        unique case (code_q)
            CMD_STATUS_LOW_BYTE: fixed_word = {8'h00, status_word[7:0]};
            CMD_STATUS_FULL_WORD: fixed_word = status_word;
            CMD_TEMPERATURE_ONE: fixed_word = temp_one_word;
            CMD_TEMPERATURE_TWO: fixed_word = temp_two_word;
            CMD_PROTOCOL_REVISION: fixed_word = {8'h00, PROTOCOL_REVISION_VALUE};
            CMD_MAKER_IDENTITY: fixed_word = {8'h00, MAKER_IDENTITY_VALUE};
            CMD_MODEL_IDENTITY: fixed_word = {8'h00, MODEL_IDENTITY_VALUE};
            CMD_SILICON_REVISION: fixed_word = {8'h00, SILICON_REVISION_VALUE};
            CMD_DOWNLOAD_CHECKSUM: fixed_word = {8'h00, download_checksum};
            CMD_READ_LENGTH: fixed_word = {8'h00, read_len_q};
            CMD_PAGE_ADDRESS_OFFSET: fixed_word = page_off_q;
            default: fixed_known = 1'b0;
        endcase
    end

    // Word answers go low byte, high byte, then zeros
    wire [7:0] fixed_byte = (idx_q == 8'h00) ? fixed_word[7:0] :
        (idx_q == 8'h01) ? fixed_word[15:8] : READ_FILL_BYTE;

    // Strobes qualified by the clock enable
    // A command outranks data or read strobes in the same cycle
    wire take_cmd = clk_en && cmd_valid && (state_q == PMSE_IDLE);
    wire take_wr = clk_en && wr_valid && !cmd_valid && (state_q == PMSE_IDLE);
    wire take_done = clk_en && wr_done && !cmd_valid && (state_q == PMSE_IDLE);
    wire take_rd = clk_en && rd_req && !cmd_valid && (state_q == PMSE_IDLE);
    wire nvm_back = clk_en && nvm_rd_valid && (state_q == PMSE_NVM_WAIT);

    // Block read: byte 0 is the count, then read_len_q data bytes
    // Bytes past the length are padded at once and skip the array
    wire blk_data_rd = take_rd && is_block && (idx_q != 8'h00) &&
        (idx_q <= read_len_q);
    wire [15:0] blk_rd_addr = page_byte_addr(page_off_q, idx_q);

    // Block write: byte 0 is the host's count, then data bytes
    // Locked or protected pages fault and leave the array alone
    wire blk_data_wr = take_wr && is_block && (idx_q != 8'h00);
    wire blk_wr_ok = page_writable(blk_page) && unlocked_q;
    wire [15:0] blk_wr_addr = page_byte_addr(page_off_q, idx_q);

    // Byte and word writes commit as their bytes arrive
    wire wr_first = take_wr && (idx_q == 8'h00);
    wire wr_len = wr_first && is_len_cmd;
    wire wr_off_lo = take_wr && is_off_cmd && (idx_q == 8'h00);
    wire wr_off_hi = take_wr && is_off_cmd && (idx_q == 8'h01);
    wire wr_wipe = wr_first && is_wipe_cmd;
    // The page sits in the low nibble; a high bit names no page
    wire wipe_ok = page_writable(wr_data[3:0]) && (wr_data[7:4] == 4'h0) &&
        unlocked_q;
    wire wr_key = wr_first && is_key_cmd;
    // Clear carries no data byte, so it commits on the stop strobe
    wire clear_cmd = take_done && is_clear_cmd && (idx_q == 8'h00);

    // Writes to read-only or unknown commands are faults
    wire wr_writable = is_block || is_len_cmd || is_off_cmd || is_wipe_cmd ||
        is_key_cmd;
    wire wr_bad = take_wr && !wr_writable;
    // Unknown reads fault on the first byte only, not on padding
    wire rd_bad = take_rd && !is_block && !fixed_known && (idx_q == 8'h00);

    // ***************************************************************
    // Unlock key sequence
    // ***************************************************************
    // The key moves only on an equal pair while unlocked, so a
    // locked host cannot rewrite it by guessing
    wire key_pair = wr_key && key_prev_vld_q && (wr_data == key_prev_q);
    wire key_match = key_pair && (wr_data == key_q);
    wire key_change = key_pair && !key_match && unlocked_q;
    // A broken pair or a wrong pair while locked relocks
    wire key_relock = wr_key && key_prev_vld_q && !key_match && !key_change;

    // A lone first write changes nothing until its partner arrives
    // Any other command between the two key writes breaks the pair
    wire key_prev_vld_d = take_cmd ? (key_prev_vld_q && (cmd_code == CMD_UNLOCK_KEY)) :
        wr_key ? !key_prev_vld_q : key_prev_vld_q;

    // Fault is sticky; a new fault in the clearing cycle survives
    wire fault_set = cml_event || (blk_data_wr && !blk_wr_ok) ||
        (wr_wipe && !wipe_ok) || wr_bad || rd_bad;
    wire cml_d = fault_set ? 1'b1 : clear_cmd ? 1'b0 : cml_q;

    // Only a page read waits; the array sets the latency
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            PMSE_IDLE: begin
                if (blk_data_rd) begin
                    state_d = PMSE_NVM_WAIT;
                end
            end
            PMSE_NVM_WAIT: begin
                if (nvm_back) begin
                    state_d = PMSE_IDLE;
                end
            end
            default: state_d = PMSE_IDLE;
        endcase
    end

    // ***************************************************************
    // Registers
    // ***************************************************************
    // The index saturates, so long reads keep padding with zeros
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= PMSE_IDLE;
            code_q <= 8'h00;
            idx_q <= 8'h00;
        end else if (clk_en) begin
            state_q <= state_d;
            if (take_cmd) begin
                code_q <= cmd_code;
                idx_q <= 8'h00;
            end else if ((take_wr || take_rd) && (idx_q != 8'hff)) begin
                idx_q <= idx_q + 8'h01;
            end
        end
    end

    // Settings and the sticky fault bit
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cml_q <= 1'b0;
            read_len_q <= READ_LENGTH_RESET;
            page_off_q <= PAGE_OFFSET_RESET;
        end else if (clk_en) begin
            cml_q <= cml_d;
            if (wr_len) begin
                read_len_q <= wr_data;
            end
            if (wr_off_lo) begin
                page_off_q[7:0] <= wr_data;
            end
            if (wr_off_hi) begin
                page_off_q[15:8] <= wr_data;
            end
        end
    end

    // The key survives until the next reset
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            unlocked_q <= 1'b0;
            key_q <= UNLOCK_KEY_RESET;
            key_prev_q <= 8'h00;
            key_prev_vld_q <= 1'b0;
        end else if (clk_en) begin
            key_prev_vld_q <= key_prev_vld_d;
            if (wr_key) begin
                key_prev_q <= wr_data;
            end
            if (key_match) begin
                unlocked_q <= 1'b1;
            end else if (key_relock) begin
                unlocked_q <= 1'b0;
            end
            if (key_change) begin
                key_q <= wr_data;
            end
        end
    end

    // Read answer: fixed bytes next cycle, page bytes when the array answers
    // rd_valid is a pulse; rd_data holds for a slow front end
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rd_valid_q <= 1'b0;
            rd_data_q <= 8'h00;
        end else if (clk_en) begin
            rd_valid_q <= (take_rd && !blk_data_rd) || nvm_back;
            if (nvm_back) begin
                rd_data_q <= nvm_rd_data;
            end else if (take_rd && is_block && (idx_q == 8'h00)) begin
                rd_data_q <= read_len_q;
            end else if (take_rd && is_block) begin
                rd_data_q <= READ_FILL_BYTE;
            end else if (take_rd) begin
                rd_data_q <= fixed_byte;
            end
        end
    end

    // Page array requests, one cycle each
    // Page, address and data hold after each request
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            nvm_rd_req_q <= 1'b0;
            nvm_wr_req_q <= 1'b0;
            nvm_erase_req_q <= 1'b0;
            nvm_page_q <= 4'h0;
            nvm_addr_q <= 16'h0000;
            nvm_wr_data_q <= 8'h00;
        end else if (clk_en) begin
            nvm_rd_req_q <= blk_data_rd;
            // Refused writes and wipes never reach the array
            nvm_wr_req_q <= blk_data_wr && blk_wr_ok;
            nvm_erase_req_q <= wr_wipe && wipe_ok;
            if (blk_data_rd) begin
                nvm_page_q <= blk_page;
                nvm_addr_q <= blk_rd_addr;
            end else if (blk_data_wr && blk_wr_ok) begin
                nvm_page_q <= blk_page;
                nvm_addr_q <= blk_wr_addr;
                nvm_wr_data_q <= wr_data;
            end else if (wr_wipe && wipe_ok) begin
                nvm_page_q <= wr_data[3:0];
                nvm_addr_q <= 16'h0000;
            end
        end
    end

    // ***************************************************************
    // Outputs
    // ***************************************************************
    // Every output is a flop, with no path from a strobe to a pin
    assign rd_valid = rd_valid_q;
    assign rd_data = rd_data_q;
    assign nvm_rd_req = nvm_rd_req_q;
    assign nvm_wr_req = nvm_wr_req_q;
    assign nvm_erase_req = nvm_erase_req_q;
    assign nvm_page = nvm_page_q;
    assign nvm_addr = nvm_addr_q;
    assign nvm_wr_data = nvm_wr_data_q;
    assign nvm_unlocked = unlocked_q;
    assign cml_fault = cml_q;

endmodule

`default_nettype wire

// ===== pmse_checker.sv
// Purpose: Port assertions for the status, identity and page command block
// Assumes: Strobes and answers as in the interpreter hand-over
// Notes: Every strobe trigger includes clk_en, since a frozen clock ignores strobes
`timescale 1ns/1ps
`default_nettype none
module pmse_checker
    import pmse_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Command side
    input wire logic clk_en,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic wr_valid,
    input wire logic [7:0] wr_data,
    input wire logic wr_done,
    input wire logic rd_req,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    input wire logic cml_event,
    input wire logic [4:0] temp_one_exponent,
    input wire logic [10:0] temp_one_mantissa,
    // Page side and status
    input wire logic nvm_wr_req,
    input wire logic nvm_erase_req,
    input wire logic [3:0] nvm_page,
    input wire logic nvm_rd_valid,
    input wire logic [7:0] nvm_rd_data,
    input wire logic nvm_unlocked,
    input wire logic cml_fault
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // ****
    // Sequences
    // ****
    sequence s_cmd(logic [7:0] c);
        clk_en && cmd_valid && cmd_code == c;
    endsequence
    sequence s_rd;
        clk_en && rd_req && !cmd_valid;
    endsequence
    // Bench leaves one idle cycle between strobes, hence ##2
    property p_status_byte;
        s_cmd(CMD_STATUS_LOW_BYTE) ##2 s_rd
        |=> rd_valid && rd_data == {6'h00, $past(cml_fault), 1'b0};
    endproperty
    a_status_byte: assert property (p_status_byte)
        else $error("status byte differs from status word low byte");
    property p_word_high;
        s_cmd(CMD_STATUS_FULL_WORD) ##2 s_rd ##2 s_rd |=> rd_valid && rd_data == 8'h00;
    endproperty
    a_word_high: assert property (p_word_high)
        else $error("status word high byte not zero");
    property p_temp_high;
        s_cmd(CMD_TEMPERATURE_ONE) ##2 s_rd ##2 s_rd
        |=> rd_data == {temp_one_exponent, temp_one_mantissa[10:8]};
    endproperty
    a_temp_high: assert property (p_temp_high)
        else $error("temperature high byte misplaced");
    property p_page_answer;
        clk_en && nvm_rd_valid |=> rd_valid && rd_data == $past(nvm_rd_data);
    endproperty
    a_page_answer: assert property (p_page_answer)
        else $error("page byte not forwarded");
    property p_fault_set;
        clk_en && cml_event |=> cml_fault;
    endproperty
    a_fault_set: assert property (p_fault_set)
        else $error("fault event not shown");
    property p_fault_fall;
        $fell(cml_fault) |-> $past(wr_done);
    endproperty
    a_fault_fall: assert property (p_fault_fall)
        else $error("fault cleared without clear command");
    property p_erase_ok;
        nvm_erase_req |-> nvm_page >= FIRST_WRITABLE_PAGE && $past(nvm_unlocked)
            && $past(wr_valid) && $past(wr_data) == {4'h0, nvm_page};
    endproperty
    a_erase_ok: assert property (p_erase_ok)
        else $error("illegal page erase");
    property p_write_ok;
        nvm_wr_req |-> nvm_page >= FIRST_WRITABLE_PAGE && $past(nvm_unlocked) && $past(wr_valid);
    endproperty
    a_write_ok: assert property (p_write_ok)
        else $error("illegal page write");
    property p_unlock_cause;
        $rose(nvm_unlocked) |-> $past(wr_valid);
    endproperty
    a_unlock_cause: assert property (p_unlock_cause)
        else $error("unlock without key byte");
    property p_refuse;
        s_cmd(CMD_PAGE_WIPE) ##2 (clk_en && wr_valid && wr_data < 8'h04)
        |=> cml_fault && !nvm_erase_req;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("protected erase not refused");
endmodule
`default_nettype wire

// ===== pmse_nvm_model.sv
// Purpose: Behavioural page array on the far side of the page port
// Assumes: Only address bits 5:0 matter; pages hold a known pattern
// Notes: Answer latency is 1 or 4 cycles; idle data toggles to expose stale use
`timescale 1ns/1ps
`default_nettype none
module pmse_nvm_model (
    // Clock and latency select
    input wire logic mclk,
    input wire logic slow,
    // Requests
    input wire logic rd_req,
    input wire logic wr_req,
    input wire logic erase_req,
    input wire logic [3:0] page,
    input wire logic [15:0] addr,
    input wire logic [7:0] wr_data,
    // Answer
    output logic rd_valid,
    output logic [7:0] rd_data
);
    logic [7:0] mem [1024];
    logic [2:0] wait_q;
    logic [9:0] ra_q;
    initial begin
        for (int i = 0; i < 1024; i++) mem[i] = 8'(i * 3);
        wait_q = 3'h0;
        rd_valid = 1'b0;
        rd_data = 8'h00;
    end
    always @(posedge mclk) begin
        rd_valid <= 1'b0;
        rd_data <= ~rd_data;
        if (wr_req) mem[{page, addr[5:0]}] <= wr_data;
        if (erase_req) for (int i = 0; i < 64; i++) mem[{page, 6'(i)}] <= 8'hff;
        if (rd_req) begin
            ra_q <= {page, addr[5:0]};
            wait_q <= slow ? 3'h4 : 3'h1;
        end else if (wait_q != 3'h0) begin
            wait_q <= wait_q - 3'h1;
            if (wait_q == 3'h1) begin
                rd_valid <= 1'b1;
                rd_data <= mem[ra_q];
            end
        end
    end
endmodule
`default_nettype wire

// ===== testbench.sv
// Purpose: Self-checking bench for the command interpreter
// Assumes: One strobe per cmd, wrb or rdb call, with one or more idle cycles after it
// Notes: Host erase wait shortened to WIPE_GAP cycles to keep the run short
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pmse_pkg::*;
    localparam int WIPE_GAP = 50;
    logic mclk, arst_n, clk_en, cmd_valid, wr_valid, wr_done, rd_req, rd_valid;
    logic cml_event, slow, nvm_rd_req, nvm_wr_req, nvm_erase_req, nvm_rd_valid;
    logic nvm_unlocked, cml_fault;
    logic [7:0] cmd_code, wr_data, rd_data, csum, nvm_wr_data, nvm_rd_data;
    logic [4:0] t1e, t2e;
    logic [10:0] t1m, t2m;
    logic [3:0] nvm_page;
    logic [15:0] nvm_addr;
    int fails = 0;
    int n_checks = 0;
    pmse_cmd_interp u_dut (.mclk(mclk), .arst_n(arst_n), .clk_en(clk_en),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .wr_valid(wr_valid),
        .wr_data(wr_data), .wr_done(wr_done), .rd_req(rd_req), .rd_valid(rd_valid),
        .rd_data(rd_data), .cml_event(cml_event), .temp_one_exponent(t1e),
        .temp_one_mantissa(t1m), .temp_two_exponent(t2e), .temp_two_mantissa(t2m),
        .download_checksum(csum), .nvm_rd_req(nvm_rd_req), .nvm_wr_req(nvm_wr_req),
        .nvm_erase_req(nvm_erase_req), .nvm_page(nvm_page), .nvm_addr(nvm_addr),
        .nvm_wr_data(nvm_wr_data), .nvm_rd_valid(nvm_rd_valid),
        .nvm_rd_data(nvm_rd_data), .nvm_unlocked(nvm_unlocked), .cml_fault(cml_fault));
    pmse_nvm_model u_nvm (.mclk(mclk), .slow(slow), .rd_req(nvm_rd_req),
        .wr_req(nvm_wr_req), .erase_req(nvm_erase_req), .page(nvm_page),
        .addr(nvm_addr), .wr_data(nvm_wr_data), .rd_valid(nvm_rd_valid),
        .rd_data(nvm_rd_data));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // ****
    // Tasks
    // ****
    task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk1(string n, logic e, logic g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic cmd(logic [7:0] c);
        cmd_valid <= 1'b1;
        cmd_code <= c;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wrb(logic [7:0] d);
        wr_valid <= 1'b1;
        wr_data <= d;
        @(posedge mclk);
        wr_valid <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic clear_faults;
        cmd(CMD_CLEAR_FAULTS);
        wr_done <= 1'b1;
        @(posedge mclk);
        wr_done <= 1'b0;
        @(posedge mclk);
        chk1("fault", 1'b0, cml_fault);
    endtask
    task automatic rdb(string n, logic [7:0] e);
        rd_req <= 1'b1;
        @(posedge mclk);
        rd_req <= 1'b0;
        for (int i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (rd_valid === 1'b1) break;
        end
        chk1("rd_valid", 1'b1, rd_valid);
        chk8(n, e, rd_data);
    endtask
    task automatic rd2(string n, logic [7:0] c, logic [7:0] e0, logic [7:0] e1);
        cmd(c);
        rdb(n, e0);
        rdb(n, e1);
    endtask
    task automatic pg(logic [3:0] p, logic [7:0] e0, logic [7:0] e1);
        cmd({CMD_PAGE_DATA_HIGH, p});
        rdb("page length", 8'h02);
        rdb("page byte", e0);
        rdb("page byte", e1);
        rdb("page beyond length", 8'h00);
    endtask
    task automatic key(logic [7:0] k0, logic [7:0] k1, logic e);
        cmd(CMD_UNLOCK_KEY);
        wrb(k0);
        cmd(CMD_UNLOCK_KEY);
        wrb(k1);
        chk1("unlocked", e, nvm_unlocked);
    endtask
    function automatic logic [7:0] pat(int p, int a);
        return 8'((p * 64 + a) * 3);
    endfunction
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ****
    // Sequence
    // ****
    initial begin
        {cmd_valid, wr_valid, wr_done, rd_req, cml_event, slow} <= 6'h00;
        clk_en <= 1'b1;
        {cmd_code, wr_data} <= 16'h0000;
        {t1e, t1m, t2e, t2m, csum} <= 40'h0;
        arst_n <= 1'b0;
        repeat (10) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        chk1("unlocked", 1'b0, nvm_unlocked);
        rd2("status word", CMD_STATUS_FULL_WORD, 8'h00, 8'h00);
        {t1e, t1m, t2e, t2m, csum} <= {5'h1b, 11'h5c3, 5'h02, 11'h2a9, 8'h9e};
        rd2("temp one", CMD_TEMPERATURE_ONE, 8'hc3, {5'h1b, 3'h5});
        rd2("temp two", CMD_TEMPERATURE_TWO, 8'ha9, {5'h02, 3'h2});
        rd2("revision", CMD_PROTOCOL_REVISION, 8'h22, 8'h00);
        rd2("maker", CMD_MAKER_IDENTITY, 8'h5a, 8'h00);
        rd2("model", CMD_MODEL_IDENTITY, 8'h3c, 8'h00);
        rd2("silicon", CMD_SILICON_REVISION, 8'h01, 8'h00);
        rd2("checksum", CMD_DOWNLOAD_CHECKSUM, 8'h9e, 8'h00);
        rd2("length", CMD_READ_LENGTH, READ_LENGTH_RESET, 8'h00);
        cmd(CMD_PAGE_WIPE);
        wrb(8'h05);
        chk1("fault", 1'b1, cml_fault);
        rd2("status byte", CMD_STATUS_LOW_BYTE, 8'h02, 8'h00);
        rd2("status word", CMD_STATUS_FULL_WORD, 8'h02, 8'h00);
        clear_faults();
        key(8'hff, 8'hff, 1'b1);
        cmd(CMD_READ_LENGTH);
        wrb(8'h02);
        cmd(CMD_PAGE_ADDRESS_OFFSET);
        wrb(8'h10);
        wrb(8'h00);
        rd2("offset", CMD_PAGE_ADDRESS_OFFSET, 8'h10, 8'h00);
        cmd(8'hb5);
        wrb(8'h01);
        wrb(8'ha7);
        cmd(8'hb2);
        wrb(8'h01);
        wrb(8'h3c);
        chk1("fault", 1'b1, cml_fault);
        clear_faults();
        pg(4'h5, 8'ha7, pat(5, 17));
        slow <= 1'b1;
        pg(4'h2, pat(2, 16), pat(2, 17));
        slow <= 1'b0;
        cmd(CMD_PAGE_WIPE);
        wrb(8'h01);
        chk1("fault", 1'b1, cml_fault);
        clear_faults();
        cmd(CMD_PAGE_WIPE);
        wrb(8'h06);
        repeat (WIPE_GAP) @(posedge mclk);
        pg(4'h6, 8'hff, 8'hff);
        key(8'h5a, 8'h5a, 1'b1);
        key(8'h12, 8'h34, 1'b0);
        cmd(8'hb7);
        wrb(8'h01);
        wrb(8'h55);
        chk1("fault", 1'b1, cml_fault);
        clear_faults();
        key(8'hff, 8'hff, 1'b0);
        key(8'h5a, 8'h5a, 1'b1);
        clk_en <= 1'b0;
        key(8'h00, 8'h01, 1'b1);
        clk_en <= 1'b1;
        cml_event <= 1'b1;
        @(posedge mclk);
        cml_event <= 1'b0;
        @(posedge mclk);
        chk1("fault", 1'b1, cml_fault);
        clear_faults();
        rd2("unknown", 8'h40, 8'h00, 8'h00);
        chk1("fault", 1'b1, cml_fault);
        summarize();
    end
    initial begin
        #(5000 * 100);
        fails++;
        summarize();
    end
endmodule
bind pmse_cmd_interp pmse_checker u_chk (.mclk, .arst_n, .clk_en, .cmd_valid, .cmd_code,
    .wr_valid, .wr_data, .wr_done, .rd_req, .rd_valid, .rd_data, .cml_event,
    .temp_one_exponent, .temp_one_mantissa, .nvm_wr_req, .nvm_erase_req, .nvm_page,
    .nvm_rd_valid, .nvm_rd_data, .nvm_unlocked, .cml_fault);
`default_nettype wire
